// file: rtl/sleep_wake_pkg.sv
// Constants, states and carriers shared by the sleep and wake controller
package sleep_wake_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 10;
    localparam int WDT_PERIOD_US = 18000;
    localparam int OSC_START_US = 10;
    localparam int OSC_START_CYCLES = OSC_START_US * CLK_MHZ;

    // ==========================================================
    // Widths and fixed values
    localparam int PC_W = 13;
    localparam int IRQ_W = 10;
    localparam int WDT_W = 18;
    localparam int OSC_W = 8;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    // Sources 0..7 may wake; 8..9 need the phase clocks
    localparam logic [IRQ_W-1:0] WAKE_MASK = 10'h0ff;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_EN_OFS = 8'h08;
    localparam logic [7:0] IRQ_FLAG_OFS = 8'h0c;
    localparam logic [7:0] WDT_COUNT_OFS = 8'h10;

    // ==========================================================
    // Field positions
    localparam int CTRL_WDT_EN_BIT = 0;
    localparam int CTRL_GIE_BIT = 1;
    localparam int CTRL_CLEAR_WDT_BIT = 2;
    localparam int STAT_ASLEEP_BIT = 0;
    localparam int STAT_OSC_BIT = 1;
    localparam int STAT_PD_BIT = 3;
    localparam int STAT_TO_BIT = 4;

    // ==========================================================
    // Reset values
    localparam logic PD_RESET = 1'b1;
    localparam logic TO_RESET = 1'b1;
    localparam logic WDT_EN_RESET = 1'b0;
    localparam logic GIE_RESET = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 10'h000;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_ASLEEP = 2'b01,
        ST_WAKING = 2'b10
    } state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] ofs;
    } dphase_t;

    typedef struct packed {
        logic push;
        logic [PC_W-1:0] pc;
    } push_t;

endpackage : sleep_wake_pkg

// file: rtl/sleep_wake_controller.sv
// Sleep entry, wake-up and interrupt vectoring for the core, with an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sleep_wake_controller #(
    parameter int unsigned WATCHDOG_CYCLES =
        sleep_wake_pkg::WDT_PERIOD_US * sleep_wake_pkg::CLK_MHZ
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleep_instr,
    input wire logic [12:0] pc,
    input wire logic [9:0] irq_flags,
    input wire logic master_clear_pin_n,
    output logic osc_enable,
    output logic io_hold,
    output logic asleep,
    output logic resume,
    output logic sleep_nop,
    output logic [12:0] prefetch_addr,
    output logic device_reset,
    output logic vector_take,
    output logic [12:0] vector_addr,
    output sleep_wake_pkg::push_t stack_push,
    output logic power_down_flag,
    output logic timeout_flag
);

    localparam logic [17:0] WDT_LAST = 18'(WATCHDOG_CYCLES - 1);
    localparam logic [7:0] OSC_LAST = 8'(sleep_wake_pkg::OSC_START_CYCLES - 1);
    localparam int OSC_BOUND = sleep_wake_pkg::OSC_START_CYCLES;

    // ==========================================================
    // State
    sleep_wake_pkg::state_t state_reg, state_next;
    sleep_wake_pkg::dphase_t dphase_reg;
    sleep_wake_pkg::push_t push_reg;
    logic [17:0] wdt_count_reg, wdt_count_next;
    logic [7:0] osc_cnt_reg, osc_cnt_next;
    logic wdt_en_reg, wdt_en_next;
    logic gie_reg, gie_next;
    logic [9:0] irq_en_reg, irq_en_next;
    logic pd_reg, pd_next;
    logic to_reg, to_next;
    logic osc_reg, io_hold_reg, resume_reg, nop_reg, reset_reg, vector_reg;
    logic [12:0] prefetch_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;

    // ==========================================================
    // Decode
    wire master_clear_pin_active = !master_clear_pin_n;
    wire in_run = (state_reg == sleep_wake_pkg::ST_RUN);
    wire in_sleep = (state_reg == sleep_wake_pkg::ST_ASLEEP);
    wire in_waking = (state_reg == sleep_wake_pkg::ST_WAKING);
    // Clocked peripherals are silenced while asleep
    wire [9:0] live_mask = in_sleep ? sleep_wake_pkg::WAKE_MASK : 10'h3ff;
    wire [9:0] irq_gated = irq_flags & live_mask;
    wire [9:0] irq_enabled = irq_gated & irq_en_reg;
    wire irq_pending = |irq_enabled;
    wire wdt_expire = wdt_en_reg && (wdt_count_reg == WDT_LAST);
    wire sleep_go = in_run && sleep_instr && !irq_pending && !master_clear_pin_active;
    wire sleep_as_nop = in_run && sleep_instr && irq_pending && !master_clear_pin_active;
    // Checked from the first asleep cycle, so a late interrupt wakes at once
    wire wake_event = in_sleep && !master_clear_pin_active && (wdt_expire || irq_pending);
    wire osc_done = in_waking && (osc_cnt_reg == OSC_LAST);
    wire vector_go = in_run && gie_reg && irq_pending && !master_clear_pin_active;
    wire wdt_reset = !in_sleep && wdt_expire;

    // ==========================================================
    // Bus decode
    wire bus_take = hsel && htrans[1] && hready;
    wire [7:0] rd_ofs = haddr[7:0];
    wire wr_ok = dphase_reg.valid && dphase_reg.write;
    wire wr_ctrl = wr_ok && (dphase_reg.ofs == sleep_wake_pkg::CTRL_OFS);
    wire wr_irq_en = wr_ok && (dphase_reg.ofs == sleep_wake_pkg::IRQ_EN_OFS);
    wire clear_wdt_cmd = wr_ctrl && hwdata[sleep_wake_pkg::CTRL_CLEAR_WDT_BIT];
    wire [31:0] ctrl_word = {30'h0, gie_reg, wdt_en_reg};
    wire [31:0] status_word = {27'h0, to_reg, pd_reg, 1'b0, osc_reg, in_sleep};
    wire [31:0] rd_data =
        (rd_ofs == sleep_wake_pkg::CTRL_OFS) ? ctrl_word :
        (rd_ofs == sleep_wake_pkg::STATUS_OFS) ? status_word :
        (rd_ofs == sleep_wake_pkg::IRQ_EN_OFS) ? {22'h0, irq_en_reg} :
        (rd_ofs == sleep_wake_pkg::IRQ_FLAG_OFS) ? {22'h0, irq_gated} :
        (rd_ofs == sleep_wake_pkg::WDT_COUNT_OFS) ? {14'h0, wdt_count_reg} :
        32'h0000_0000;

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        osc_cnt_next = 8'h00;
        case (state_reg)
            sleep_wake_pkg::ST_RUN: begin
                if (sleep_go) begin
                    state_next = sleep_wake_pkg::ST_ASLEEP;
                end
            end
            sleep_wake_pkg::ST_ASLEEP: begin
                if (master_clear_pin_active) begin
                    state_next = sleep_wake_pkg::ST_RUN;
                end else if (wake_event) begin
                    state_next = sleep_wake_pkg::ST_WAKING;
                end
            end
            sleep_wake_pkg::ST_WAKING: begin
                osc_cnt_next = 8'(osc_cnt_reg + 8'h01);
                if (master_clear_pin_active || osc_done) begin
                    state_next = sleep_wake_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = sleep_wake_pkg::ST_RUN;
            end
        endcase
    end

    // ==========================================================
    // Watchdog, flags and control
    always_comb begin
        wdt_count_next = wdt_count_reg;
        if (master_clear_pin_active || sleep_go || clear_wdt_cmd || wdt_expire) begin
            wdt_count_next = 18'h00000;
        end else if (wdt_en_reg) begin
            wdt_count_next = 18'(wdt_count_reg + 18'h00001);
        end
    end

    always_comb begin
        pd_next = pd_reg;
        to_next = to_reg;
        if (sleep_go) begin
            pd_next = 1'b0;
            to_next = 1'b1;
        end else if (wdt_expire) begin
            to_next = 1'b0;
        end else if (clear_wdt_cmd) begin
            pd_next = 1'b1;
            to_next = 1'b1;
        end
    end

    always_comb begin
        wdt_en_next = wr_ctrl ? hwdata[sleep_wake_pkg::CTRL_WDT_EN_BIT] : wdt_en_reg;
        irq_en_next = wr_irq_en ? hwdata[9:0] : irq_en_reg;
        // Taking a vector drops the enable; a software write still wins
        gie_next = vector_go ? 1'b0 : gie_reg;
        if (wr_ctrl) begin
            gie_next = hwdata[sleep_wake_pkg::CTRL_GIE_BIT];
        end
        if (master_clear_pin_active || wdt_reset) begin
            gie_next = sleep_wake_pkg::GIE_RESET;
            irq_en_next = sleep_wake_pkg::IRQ_EN_RESET;
            wdt_en_next = sleep_wake_pkg::WDT_EN_RESET;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= sleep_wake_pkg::ST_RUN;
            osc_cnt_reg <= 8'h00;
            wdt_count_reg <= 18'h00000;
            pd_reg <= sleep_wake_pkg::PD_RESET;
            to_reg <= sleep_wake_pkg::TO_RESET;
            wdt_en_reg <= sleep_wake_pkg::WDT_EN_RESET;
            gie_reg <= sleep_wake_pkg::GIE_RESET;
            irq_en_reg <= sleep_wake_pkg::IRQ_EN_RESET;
        end else begin
            state_reg <= state_next;
            osc_cnt_reg <= osc_cnt_next;
            wdt_count_reg <= wdt_count_next;
            pd_reg <= pd_next;
            to_reg <= to_next;
            wdt_en_reg <= wdt_en_next;
            gie_reg <= gie_next;
            irq_en_reg <= irq_en_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_reg <= 1'b1;
            io_hold_reg <= 1'b0;
            resume_reg <= 1'b0;
            nop_reg <= 1'b0;
            reset_reg <= 1'b0;
            vector_reg <= 1'b0;
        end else begin
            osc_reg <= (state_next != sleep_wake_pkg::ST_ASLEEP);
            io_hold_reg <= (state_next == sleep_wake_pkg::ST_ASLEEP);
            resume_reg <= osc_done && !master_clear_pin_active;
            nop_reg <= sleep_as_nop;
            reset_reg <= master_clear_pin_active || wdt_reset;
            vector_reg <= vector_go;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prefetch_reg <= 13'h0000;
            push_reg <= '0;
        end else begin
            if (sleep_go) begin
                prefetch_reg <= 13'(pc + 13'h0001);
            end
            push_reg.push <= vector_go;
            push_reg.pc <= vector_go ? pc : 13'h0000;
        end
    end

    // ==========================================================
    // Bus slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_reg <= '0;
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            if (hready) begin
                dphase_reg.valid <= bus_take;
                dphase_reg.write <= hwrite;
                dphase_reg.ofs <= rd_ofs;
            end
            if (bus_take && !hwrite) begin
                hrdata_reg <= rd_data;
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign osc_enable = osc_reg;
    assign io_hold = io_hold_reg;
    assign asleep = io_hold_reg;
    assign resume = resume_reg;
    assign sleep_nop = nop_reg;
    assign prefetch_addr = prefetch_reg;
    assign device_reset = reset_reg;
    assign vector_take = vector_reg;
    assign vector_addr = sleep_wake_pkg::IRQ_VECTOR;
    assign stack_push = push_reg;
    assign power_down_flag = pd_reg;
    assign timeout_flag = to_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_enter;
        sleep_go && wdt_en_reg;
    endsequence

    sequence s_wake;
        wake_event;
    endsequence

    sequence s_restart;
        osc_enable && !resume ##OSC_BOUND resume;
    endsequence

    wdt_clear_a: assert property (s_enter |=> wdt_count_reg == 18'h00000)
        else $error("watchdog not cleared on sleep entry");
    flag_update_a: assert property (sleep_go |=> !power_down_flag && timeout_flag)
        else $error("flags not updated on sleep entry");
    osc_off_a: assert property (sleep_go |=> !osc_enable && io_hold)
        else $error("oscillator or hold wrong after entry");
    hold_stable_a: assert property (io_hold && $past(io_hold) |-> !osc_enable)
        else $error("hold without stopped oscillator");
    master_clear_pin_reset_a: assert property (in_sleep && master_clear_pin_active |=> device_reset && in_run)
        else $error("master clear in sleep did not reset");
    wdt_wake_a: assert property (in_sleep && wdt_expire && !master_clear_pin_active |=> !timeout_flag && in_waking)
        else $error("watchdog wake wrong");
    no_clk_irq_a: assert property (in_sleep && !wdt_expire && !master_clear_pin_active && ((irq_flags & irq_en_reg & sleep_wake_pkg::WAKE_MASK) == 10'h000) |=> !in_waking)
        else $error("woken by clocked peripheral");
    prefetch_a: assert property (sleep_go |=> prefetch_addr == 13'($past(pc) + 13'h0001))
        else $error("prefetch address wrong");
    nop_sleep_a: assert property (sleep_as_nop |=> sleep_nop && $stable(power_down_flag) && $stable(timeout_flag) && in_run)
        else $error("pending interrupt did not make sleep a no-op");
    restart_seq_a: assert property (disable iff (!hresetn || master_clear_pin_active) s_wake |=> s_restart)
        else $error("oscillator restart sequence wrong");
    no_vector_a: assert property (resume && !gie_reg |=> !vector_take)
        else $error("vector taken with global enable clear");
    vector_after_a: assert property (resume && gie_reg && irq_pending && !master_clear_pin_active |=> vector_take && stack_push.push && stack_push.pc == $past(pc))
        else $error("vector not taken after resume");

endmodule : sleep_wake_controller

`default_nettype wire

// file: verification/core_model.sv
// Core pipeline stand-in: a program counter that halts while asleep
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic asleep,
    input wire logic vector_take,
    input wire logic [12:0] vector_addr,
    input wire logic device_reset,
    output logic [12:0] pc
);
    // ==========================================================
    // Program counter
    // Word after sleep is treated as a no-op, so stepping is enough
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= 13'h0000;
        end else if (device_reset) begin
            pc <= 13'h0000;
        end else if (vector_take) begin
            pc <= vector_addr;
        end else if (!asleep) begin
            pc <= pc + 13'h0001;
        end
    end
endmodule : core_model

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ==========================================================
    // Signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic hreadyout, hresp, osc_enable, io_hold, asleep, resume, sleep_nop;
    logic device_reset, vector_take, power_down_flag, timeout_flag;
    logic [31:0] hrdata;
    logic sleep_instr = 1'b0;
    logic [12:0] pc, prefetch_addr, vector_addr;
    logic [9:0] irq_flags = 10'h000;
    logic master_clear_pin_n = 1'b1;
    sleep_wake_pkg::push_t stack_push;
    logic [31:0] rd;
    int n;
    logic woke;
    logic [12:0] ret_pc;
    int comparisons = 0;
    int miscompares = 0;

    assign hready = hreadyout;
    always #50 hclk = ~hclk;

    sleep_wake_controller #(.WATCHDOG_CYCLES(200)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_instr(sleep_instr),
        .pc(pc), .irq_flags(irq_flags), .master_clear_pin_n(master_clear_pin_n),
        .osc_enable(osc_enable), .io_hold(io_hold), .asleep(asleep), .resume(resume),
        .sleep_nop(sleep_nop), .prefetch_addr(prefetch_addr), .device_reset(device_reset),
        .vector_take(vector_take), .vector_addr(vector_addr), .stack_push(stack_push),
        .power_down_flag(power_down_flag), .timeout_flag(timeout_flag)
    );

    core_model i_core (
        .hclk(hclk), .hresetn(hresetn), .asleep(asleep), .vector_take(vector_take),
        .vector_addr(vector_addr), .device_reset(device_reset), .pc(pc)
    );

    // ==========================================================
    // Tasks
    task finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task wait_ready;
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                miscompares++;
                finish_test();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    // Called just after a rising edge
    task ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string msg);
        ahb(1'b0, ofs, 32'h00000000);
        check(rd, exp, msg);
        check(hresp, 0, "okay response");
    endtask : rd_chk

    task wait_resume(input int limit);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (resume !== 1'b1 && n < limit);
    endtask : wait_resume

    task enter_sleep(input logic [9:0] irq_at_entry);
        logic [12:0] exp_pf;
        @(posedge hclk);
        sleep_instr <= 1'b1;
        #1 exp_pf = pc + 13'h0001;
        @(posedge hclk);
        sleep_instr <= 1'b0;
        irq_flags <= irq_at_entry;
        #1;
        check(io_hold, 1, "io hold");
        check(asleep, 1, "asleep");
        check(osc_enable, 0, "osc off");
        check(power_down_flag, 0, "pd clear");
        check(timeout_flag, 1, "to set");
        check(prefetch_addr, exp_pf, "prefetch");
    endtask : enter_sleep

    // ==========================================================
    // Sequence
    initial begin
        #(100 * 30000);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(power_down_flag, 1, "pd at power-up");
        rd_chk(sleep_wake_pkg::STATUS_OFS, 32'h0000001a, "status reset");
        rd_chk(8'h20, 32'h00000000, "unmapped");
        ahb(1'b1, sleep_wake_pkg::IRQ_EN_OFS, 32'h000003fd);
        // Pending enabled flag turns sleep into a no-op
        irq_flags <= 10'h001;
        @(posedge hclk);
        sleep_instr <= 1'b1;
        @(posedge hclk);
        sleep_instr <= 1'b0;
        #1;
        check(sleep_nop, 1, "nop");
        check(power_down_flag, 1, "pd kept");
        check(io_hold, 0, "not asleep");
        @(posedge hclk);
        irq_flags <= 10'h000;
        // Each source; bit 1 not enabled, bits 8..9 need phase clocks
        for (int i = 0; i < 10; i++) begin
            enter_sleep(10'h001 << i);
            wait_resume(150);
            woke = (i < 8 && i != 1);
            check(resume, woke, "wake source");
            if (!woke) begin
                irq_flags <= 10'h001;
                wait_resume(150);
            end
            check(n >= 100 && n <= 102, 1, "osc start time");
            check(osc_enable, 1, "osc on at resume");
            check(device_reset, 0, "no reset");
            @(posedge hclk);
            irq_flags <= 10'h000;
            #1 check(vector_take, 0, "no vector");
        end
        // Global enable set, flag rising as sleep completes
        ahb(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h00000002);
        enter_sleep(10'h001);
        wait_resume(150);
        check(resume, 1, "irq wake");
        ret_pc = pc;
        @(posedge hclk);
        #1;
        check(vector_take, 1, "vector");
        check(vector_addr, 13'h0004, "vector addr");
        check(stack_push.push, 1, "push");
        check(stack_push.pc, ret_pc, "return pc");
        irq_flags <= 10'h000;
        @(posedge hclk);
        // Watchdog cleared by software first, then by sleep
        ahb(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h00000005);
        enter_sleep(10'h000);
        ahb(1'b0, sleep_wake_pkg::WDT_COUNT_OFS, 32'h00000000);
        check(rd < 8, 1, "wdt cleared");
        wait_resume(350);
        check(n > 280 && n < 310, 1, "wdt wake time");
        check(timeout_flag, 0, "to cleared");
        check(device_reset, 0, "wake not reset");
        @(posedge hclk);
        ahb(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h00000000);
        // Master clear while asleep
        enter_sleep(10'h000);
        @(posedge hclk);
        master_clear_pin_n <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        check(device_reset, 1, "master_clear_pin reset");
        check(io_hold, 0, "reset leaves sleep");
        @(posedge hclk);
        master_clear_pin_n <= 1'b1;
        repeat (2) @(posedge hclk);
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
